// [adc_core.sv]
// Notes on behaviour
// - latch multiplexed low address byte internally
// - port C bit two is a decoder logic input
// - port C bit one drives decoded interrupt request
// - port A bits individually configurable I/O
// - port B bits zero, one individually I/O
// - latch and buffer selects built from address, strobe, read/write; eprom and sram selects from address
// - latch select only on writes to page
// - write latch and read buffer share address
// - each 4K eprom block placed independently
// - program blocks at 6000-9FFF and C000-FFFF
// - sram window placed by configurable base
// - port registers paired at I/O base offsets
// - one 16-bit access reaches both ports
// - latch page 0010, read/write splits selects
// - reset and latch-enable polarity are options
`timescale 1ns/1ps
`default_nettype none
module adc_core
	import adc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_host_reset,
	input wire logic i_reset_active_high,
	input wire logic i_ale_active_high,
	input wire logic i_ale,
	input wire logic i_host_data_strobe,
	input wire logic i_rw,
	input wire logic [7:0] i_addr_hi,
	input wire logic [7:0] i_ad,
	output logic [7:0] o_ad,
	output logic o_ad_oe,
	input wire logic [31:0] i_eprom_map,
	input wire logic [3:0] i_sram_base,
	input wire logic [3:0] i_io_base,
	input wire logic [3:0] i_latch_page,
	input wire logic [7:0] i_port_a,
	output logic [7:0] o_port_a,
	output logic [7:0] o_port_a_oe,
	input wire logic i_port_b_bit_zero,
	output logic o_port_b_bit_zero,
	output logic o_port_b_bit_zero_oe,
	input wire logic i_port_b_bit_one,
	output logic o_port_b_bit_one,
	output logic o_port_b_bit_one_oe,
	input wire logic i_port_c_bit_two_input,
	input wire logic i_irq_invert,
	output logic o_port_c_bit_one_select,
	output logic o_latch_write_select_n,
	output logic o_buffer_read_select_n,
	output logic [7:0] o_eprom_block_sel,
	output logic o_program_segment_upper,
	output logic o_program_segment_lower,
	output logic o_sram_sel
);

	// pin bundle: reset, ale, strobe, rw, high address, ad, port a, port b, port c logic input
	localparam int PW = 32;
	logic [PW-1:0] pins_raw; // raw pin levels
	logic [PW-1:0] sync1_r; // first stage, read only by the second
	logic [PW-1:0] sync2_r; // second stage, safe to use
	logic host_rst_s, ale_s, stb_s, rw_s, bz_s, bo_s, key_s;
	logic chip_up_r; // low until the first edge after the chip reset, whatever the pin polarity
	logic [7:0] addr_hi_s, ad_s, pa_s;

	// state: latched address byte, port registers, read data
	logic [7:0] addr_lo_r, addr_lo_nxt;
	logic [7:0] dir_a_r, dir_a_nxt;
	logic [7:0] data_a_r, data_a_nxt;
	logic [1:0] dir_b_r, dir_b_nxt; // only bits zero and one exist on port b
	logic [1:0] data_b_r, data_b_nxt;
	logic [7:0] ad_r, ad_nxt;
	logic live; // high when neither reset is active
	logic ale_act; // latch enable after polarity option
	logic io_wr; // host write into the port window
	logic [7:0] pb_view;

	adc_dec_if dbus ();

	assign pins_raw = {i_host_reset, i_ale, i_host_data_strobe, i_rw, i_addr_hi, i_ad, i_port_a,
		i_port_b_bit_zero, i_port_b_bit_one, i_port_c_bit_two_input, 1'b0};

	// two-stage synchroniser on every pin the host or the outside world drives
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			chip_up_r <= 1'b0;
		end
		else
		begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
			chip_up_r <= 1'b1;
		end
	end

	assign {host_rst_s, ale_s, stb_s, rw_s, addr_hi_s, ad_s, pa_s, bz_s, bo_s, key_s} = sync2_r[PW-1:1];

	// polarity options for the host reset pin and the latch enable
	// chip reset zeroes the synchronisers, which an active-high pin option would read as running
	assign live = chip_up_r && (i_reset_active_high ? !host_rst_s : host_rst_s);
	assign ale_act = i_ale_active_high ? ale_s : !ale_s;

	// decoder hookup; config comes straight from the configuration ports
	assign dbus.addr = {addr_hi_s, addr_lo_r};
	assign dbus.stb = stb_s;
	assign dbus.rw = rw_s;
	assign dbus.live = live;
	assign dbus.eprom_map = i_eprom_map;
	assign dbus.sram_base = i_sram_base;
	assign dbus.io_base = i_io_base;
	assign dbus.latch_page = i_latch_page;

	adc_decode u_decode (
		.bus(dbus.dec)
	);

	assign io_wr = dbus.io_sel && !rw_s;
	assign pb_view = adc_port_view({6'h00, dir_b_r}, {6'h00, data_b_r}, {6'h00, bz_s, bo_s});

	// next values of address latch, port registers and read data
	always_comb
	begin
		addr_lo_nxt = addr_lo_r;
		dir_a_nxt = dir_a_r;
		data_a_nxt = data_a_r;
		dir_b_nxt = dir_b_r;
		data_b_nxt = data_b_r;
		ad_nxt = ad_r;
		if (!live)
		begin
			// host reset pin clears like the power-on reset
			addr_lo_nxt = 8'h00;
			dir_a_nxt = ADC_DIR_RST;
			data_a_nxt = ADC_DATA_RST;
			dir_b_nxt = ADC_DIR_RST[1:0];
			data_b_nxt = ADC_DATA_RST[1:0];
			ad_nxt = 8'h00;
		end
		else
		begin
			// transparent while enabled, holds once the enable drops
			if (ale_act)
			begin
				addr_lo_nxt = ad_s;
			end
			// strobe is a level, so a write repeats harmlessly while it stays high
			if (io_wr)
			begin
				unique case (addr_lo_r[1:0])
					ADC_OFS_DIR_A: dir_a_nxt = ad_s;
					ADC_OFS_DIR_B: dir_b_nxt = ad_s[1:0];
					ADC_OFS_DATA_A: data_a_nxt = ad_s;
					ADC_OFS_DATA_B: data_b_nxt = ad_s[1:0];
				endcase
			end
			// direction pair then data pair, so one 16-bit access spans a and b
			unique case (addr_lo_r[1:0])
				ADC_OFS_DIR_A: ad_nxt = dir_a_r;
				ADC_OFS_DIR_B: ad_nxt = {6'h00, dir_b_r};
				ADC_OFS_DATA_A: ad_nxt = adc_port_view(dir_a_r, data_a_r, pa_s);
				ADC_OFS_DATA_B: ad_nxt = pb_view;
			endcase
		end
	end

	// register the state; only constants under the asynchronous reset
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			addr_lo_r <= 8'h00;
			dir_a_r <= ADC_DIR_RST;
			data_a_r <= ADC_DATA_RST;
			dir_b_r <= ADC_DIR_RST[1:0];
			data_b_r <= ADC_DATA_RST[1:0];
			ad_r <= 8'h00;
		end
		else
		begin
			addr_lo_r <= addr_lo_nxt;
			dir_a_r <= dir_a_nxt;
			data_a_r <= data_a_nxt;
			dir_b_r <= dir_b_nxt;
			data_b_r <= data_b_nxt;
			ad_r <= ad_nxt;
		end
	end

	// bus drive only during a host read of the port window
	assign o_ad = ad_r;
	assign o_ad_oe = dbus.io_sel && rw_s;

	// port pins follow their direction bits
	assign o_port_a = data_a_r;
	assign o_port_a_oe = dir_a_r;
	assign o_port_b_bit_zero = data_b_r[1];
	assign o_port_b_bit_zero_oe = dir_b_r[1];
	assign o_port_b_bit_one = data_b_r[0];
	assign o_port_b_bit_one_oe = dir_b_r[0];

	// the port c input is a logic term; inversion suits an active-high key-ready into an active-low irq
	assign o_port_c_bit_one_select = live ? (key_s ^ i_irq_invert) : 1'b1;

	// decoder outputs, combinational so they track the strobe closely
	assign o_latch_write_select_n = dbus.latch_wr_n;
	assign o_buffer_read_select_n = dbus.buf_rd_n;
	assign o_eprom_block_sel = dbus.eprom_sel;
	assign o_program_segment_lower = |dbus.eprom_sel[3:0];
	assign o_program_segment_upper = |dbus.eprom_sel[7:4];
	assign o_sram_sel = dbus.sram_sel;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	latch_write_only_a: assert property (!o_latch_write_select_n |->
		(stb_s && !rw_s && addr_hi_s[7:4] == i_latch_page))
		else $error("latch select outside a write to its page");
	buffer_read_only_a: assert property (!o_buffer_read_select_n |->
		(stb_s && rw_s && addr_hi_s[7:4] == i_latch_page))
		else $error("buffer select outside a read of its page");
	shared_page_a: assert property (!(!o_latch_write_select_n && !o_buffer_read_select_n))
		else $error("latch and buffer selected together");
	reset_quiet_a: assert property (!live |->
		(o_latch_write_select_n && o_buffer_read_select_n && o_eprom_block_sel == 8'h00 && !o_sram_sel && !o_ad_oe))
		else $error("select active during reset");
	irq_follow_a: assert property ((live && $past(live, 3)) |->
		o_port_c_bit_one_select == ($past(i_port_c_bit_two_input, 2) ^ i_irq_invert))
		else $error("interrupt select does not follow its logic input");
	addr_catch_a: assert property ((live && ale_act) |=> addr_lo_r == $past(ad_s))
		else $error("address byte not latched");
	port_write_a: assert property ((io_wr && addr_lo_r[1:0] == ADC_OFS_DATA_A) |=> data_a_r == $past(ad_s))
		else $error("port a data write lost");
	eprom_onehot_a: assert property ($onehot0(o_eprom_block_sel) || i_eprom_map != ADC_EPROM_MAP)
		else $error("two eprom blocks selected");
	segment_split_a: assert property ((i_eprom_map == ADC_EPROM_MAP && live && addr_hi_s[7:4] == 4'hc)
		|-> o_program_segment_upper && !o_program_segment_lower)
		else $error("c000 page not in upper program segment");

endmodule
`default_nettype wire

// [adc_dec_if.sv]
`timescale 1ns/1ps
`default_nettype none
// signals between the bus core and the address decoder
interface adc_dec_if;
	logic [15:0] addr; // latched low byte plus high byte
	logic stb; // host data strobe, synchronised
	logic rw; // high for read
	logic live; // low while reset holds
	logic [31:0] eprom_map;
	logic [3:0] sram_base;
	logic [3:0] io_base;
	logic [3:0] latch_page;
	logic [7:0] eprom_sel;
	logic sram_sel;
	logic io_sel;
	logic io_page;
	logic latch_wr_n;
	logic buf_rd_n;
	modport core (output addr, stb, rw, live, eprom_map, sram_base, io_base, latch_page,
		input eprom_sel, sram_sel, io_sel, io_page, latch_wr_n, buf_rd_n);
	modport dec (input addr, stb, rw, live, eprom_map, sram_base, io_base, latch_page,
		output eprom_sel, sram_sel, io_sel, io_page, latch_wr_n, buf_rd_n);
endinterface
`default_nettype wire

// [adc_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_decode
	import adc_pkg::*;
(
	adc_dec_if.dec bus
);

	// pure decode of the latched address, strobe and read/write level
	always_comb
	begin
		// each 4k block compares its own page nibble, so blocks may scatter
		for (int k = 0; k < ADC_EPROM_BLOCKS; k++)
		begin
			bus.eprom_sel[k] = bus.live && (bus.addr[15:12] == bus.eprom_map[k*4 +: 4]);
		end
		bus.sram_sel = bus.live && (bus.addr[15:12] == bus.sram_base);
		bus.io_page = bus.live && (bus.addr[15:12] == bus.io_base);
		bus.io_sel = bus.io_page && bus.stb;
		// same page, split by direction: writes go to the latch, reads to the buffer
		bus.latch_wr_n = !(bus.live && bus.stb && !bus.rw && bus.addr[15:12] == bus.latch_page);
		bus.buf_rd_n = !(bus.live && bus.stb && bus.rw && bus.addr[15:12] == bus.latch_page);
	end

endmodule
`default_nettype wire

// [adc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host side of the shared bus: an ale phase first, then a strobe phase
module adc_host_model (
	input wire logic i_clk,
	input wire logic [7:0] i_dev_ad,
	input wire logic i_dev_ad_oe,
	output logic o_ale,
	output logic o_strobe,
	output logic o_rw,
	output logic [7:0] o_addr_hi,
	output logic [7:0] o_ad
);
	logic drv = 1'b1; // host owns the shared lines
	logic [7:0] val = 8'h00; // last value the host put out
	// idle bus: no ale, no strobe, read level so nothing is written by accident
	initial
	begin
		o_ale = 1'b0;
		o_strobe = 1'b0;
		o_rw = 1'b1;
		o_addr_hi = 8'h00;
	end
	// released lines show the device, else the inverse of the last value so no stale match
	assign o_ad = drv ? val : (i_dev_ad_oe ? i_dev_ad : ~val);
	// ale held three clocks so the synchronised latch surely sees it
	task automatic addr(input logic [15:0] a);
		@(posedge i_clk);
		o_ale <= 1'b1;
		o_addr_hi <= a[15:8];
		val <= a[7:0];
		drv <= 1'b1;
		repeat (3) @(posedge i_clk);
		o_ale <= 1'b0;
	endtask
	// strobe high four clocks: longer than the sync lag plus the read register
	task automatic strobe_on(input logic r, input logic [7:0] d);
		@(posedge i_clk);
		o_strobe <= 1'b1;
		o_rw <= r;
		val <= d;
		drv <= !r;
		repeat (4) @(posedge i_clk);
	endtask
	// strobe drops; address stays until the next ale phase
	task automatic strobe_off();
		@(posedge i_clk);
		o_strobe <= 1'b0;
		o_rw <= 1'b1;
		drv <= 1'b1;
		repeat (3) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// [adc_pkg.sv]
`default_nettype none
package adc_pkg;

	// described configuration: latch and buffer page, sram and port windows
	localparam logic [3:0] ADC_LATCH_PAGE = 4'h2;
	localparam logic [3:0] ADC_SRAM_BASE = 4'h5;
	localparam logic [3:0] ADC_IO_BASE = 4'h4;
	// one nibble per 4k eprom block, block 0 in the low nibble
	localparam logic [31:0] ADC_EPROM_MAP = 32'hfedc9876;
	localparam int ADC_EPROM_BLOCKS = 8;

	// paired port registers, offsets from the i/o base
	localparam logic [1:0] ADC_OFS_DIR_A = 2'h0;
	localparam logic [1:0] ADC_OFS_DIR_B = 2'h1;
	localparam logic [1:0] ADC_OFS_DATA_A = 2'h2;
	localparam logic [1:0] ADC_OFS_DATA_B = 2'h3;

	// reset values: all port pins inputs, data cleared
	localparam logic [7:0] ADC_DIR_RST = 8'h00;
	localparam logic [7:0] ADC_DATA_RST = 8'h00;

	// per bit: an output shows its data register, an input shows its pin
	function automatic logic [7:0] adc_port_view(input logic [7:0] dir, input logic [7:0] data,
		input logic [7:0] pins);
		adc_port_view = (dir & data) | (~dir & pins);
	endfunction

endpackage
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the decoder and paired ports
module testbench;
	import adc_pkg::*;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic hr = 1'b1; // host reset pin, its active level set by rp
	logic rp = 1'b0; // host reset polarity option, 0 = active low
	logic ap = 1'b1; // latch enable polarity option, 1 = active high
	logic inv = 1'b0;
	logic key_rdy = 1'b0; // port c logic input pin
	logic pin_bz = 1'b0; // port b bit zero pin
	logic pin_bo = 1'b0; // port b bit one pin
	logic [7:0] pa = 8'h00;
	logic [31:0] map = ADC_EPROM_MAP;
	logic [7:0] dir_a, dir_b, dat_a, dat_b; // expected port registers
	logic ale, stb, rw, ad_oe, bz_o, bz_oe, bo_o, bo_oe, irq_o, lw_n, br_n, up, lo, sram;
	logic [7:0] hi, ad, ad_d, pa_o, pa_oe, eps;
	int err_total = 0;
	int checked = 0;
	logic [31:0] seed = 32'h1d824e93;
	always #25 i_clk = ~i_clk;
	adc_host_model u_host (.i_clk(i_clk), .i_dev_ad(ad_d), .i_dev_ad_oe(ad_oe), .o_ale(ale), .o_strobe(stb),
		.o_rw(rw), .o_addr_hi(hi), .o_ad(ad));
	// the host always pulses ale high; the pin is inverted when the option asks for an active-low enable
	adc_core u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_host_reset(hr), .i_reset_active_high(rp),
		.i_ale_active_high(ap), .i_ale(ap ? ale : !ale), .i_host_data_strobe(stb), .i_rw(rw), .i_addr_hi(hi),
		.i_ad(ad), .o_ad(ad_d), .o_ad_oe(ad_oe), .i_eprom_map(map), .i_sram_base(ADC_SRAM_BASE),
		.i_io_base(ADC_IO_BASE), .i_latch_page(ADC_LATCH_PAGE), .i_port_a(pa), .o_port_a(pa_o),
		.o_port_a_oe(pa_oe), .i_port_b_bit_zero(pin_bz), .o_port_b_bit_zero(bz_o),
		.o_port_b_bit_zero_oe(bz_oe), .i_port_b_bit_one(pin_bo), .o_port_b_bit_one(bo_o),
		.o_port_b_bit_one_oe(bo_oe), .i_port_c_bit_two_input(key_rdy), .i_irq_invert(inv),
		.o_port_c_bit_one_select(irq_o), .o_latch_write_select_n(lw_n), .o_buffer_read_select_n(br_n),
		.o_eprom_block_sel(eps), .o_program_segment_upper(up), .o_program_segment_lower(lo),
		.o_sram_sel(sram));
	// xorshift keeps the random run repeatable
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected block selects for a page, one bit for each block mapped to it
	function automatic logic [7:0] blocks(input logic [3:0] pg);
		for (int k = 0; k < 8; k++)
			blocks[k] = (map[4*k +: 4] == pg);
	endfunction
	// outputs show their data bit, inputs their pin
	function automatic logic [7:0] view(input logic [7:0] d, input logic [7:0] q, input logic [7:0] p);
		return (d & q) | (~d & p);
	endfunction
	function automatic logic [7:0] rd_exp(input logic [1:0] o);
		case (o)
			ADC_OFS_DIR_A: return dir_a;
			ADC_OFS_DIR_B: return dir_b;
			ADC_OFS_DATA_A: return view(dir_a, dat_a, pa);
			default: return view(dir_b, dat_b, {6'h00, pin_bz, pin_bo});
		endcase
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one host cycle: selects judged mid-strobe, latch and buffer selects again once the strobe is gone
	task automatic bus(input logic [15:0] a, input logic r, input logic [7:0] d);
		logic [3:0] pg;
		logic [7:0] ev;
		pg = a[15:12];
		u_host.addr(a);
		u_host.strobe_on(r, d);
		// block map read here, after any map change made at the call's own edge has settled
		ev = blocks(pg);
		// the model follows only writes that land in the port window; they land while the strobe is high
		if (!r && pg == ADC_IO_BASE)
			case (a[1:0])
				ADC_OFS_DIR_A: dir_a = d;
				ADC_OFS_DIR_B: dir_b = {6'h00, d[1:0]};
				ADC_OFS_DATA_A: dat_a = d;
				default: dat_b = {6'h00, d[1:0]};
			endcase
		#1;
		chk("latch_sel_n", lw_n, !(pg == ADC_LATCH_PAGE && !r));
		chk("buffer_sel_n", br_n, !(pg == ADC_LATCH_PAGE && r));
		chk("eprom_sel", eps, ev);
		chk("segments", {up, lo}, {|ev[7:4], |ev[3:0]});
		chk("sram_sel", sram, pg == ADC_SRAM_BASE);
		chk("irq_sel", irq_o, key_rdy ^ inv);
		chk("port_a", {pa_oe, pa_o}, {dir_a, dat_a});
		chk("port_b", {bz_oe, bo_oe, bz_o, bo_o}, {dir_b[1:0], dat_b[1:0]});
		chk("ad_oe", ad_oe, r && pg == ADC_IO_BASE);
		if (r && pg == ADC_IO_BASE)
			chk("read_data", ad_d, rd_exp(a[1:0]));
		u_host.strobe_off();
		#1;
		chk("idle_sel", {lw_n, br_n}, 2'b11);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// main sequence: corners, random traffic, host reset
	initial
	begin
		logic [31:0] r;
		logic [15:0] a;
		{dir_a, dir_b, dat_a, dat_b} = '0;
		repeat (16) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_clk);
		// all four registers back to back, then a write outside the window that must not land
		for (int o = 0; o < 4; o++)
			bus({ADC_IO_BASE, 10'h000, o[1:0]}, 1'b0, 8'hff);
		bus({4'h3, 12'h002}, 1'b0, 8'h00);
		for (int o = 0; o < 4; o++)
			bus({ADC_IO_BASE, 10'h000, o[1:0]}, 1'b1, 8'h00);
		for (int i = 0; i < 120; i++)
		begin
			r = rnd();
			@(posedge i_clk);
			// halfway the block map turns random, so blocks may collide or scatter
			if (i == 60)
				map <= rnd();
			pa <= r[15:8];
			{pin_bz, pin_bo, key_rdy, inv} <= r[19:16];
			a = r[31:16];
			if (r[2])
				a[15:12] = r[3] ? ADC_IO_BASE : ADC_LATCH_PAGE;
			bus(a, r[4], r[7:0]);
		end
		// host reset pin: selects held off, interrupt line parked high, ports cleared
		@(posedge i_clk);
		hr <= 1'b0;
		u_host.addr({ADC_LATCH_PAGE, 12'h000});
		u_host.strobe_on(1'b0, 8'h5a);
		#1;
		chk("held_sel", {lw_n, irq_o, pa_oe}, {1'b1, 1'b1, 8'h00});
		u_host.strobe_off();
		hr <= 1'b1;
		{dir_a, dir_b, dat_a, dat_b} = '0;
		repeat (4) @(posedge i_clk);
		bus({ADC_IO_BASE, 12'h000}, 1'b1, 8'h00);
		bus({ADC_IO_BASE, 12'h000}, 1'b0, 8'ha5);
		// swap both options: the pin, still high, now means reset; the enable now acts when low
		@(posedge i_clk);
		rp <= 1'b1;
		ap <= 1'b0;
		repeat (4) @(posedge i_clk);
		#1;
		chk("held_hi", {br_n, irq_o, pa_oe}, {1'b1, 1'b1, 8'h00});
		@(posedge i_clk);
		hr <= 1'b0;
		{dir_a, dir_b, dat_a, dat_b} = '0;
		repeat (4) @(posedge i_clk);
		bus({ADC_IO_BASE, 12'h002}, 1'b0, 8'h3c);
		bus({ADC_IO_BASE, 12'h002}, 1'b1, 8'h00);
		finish_test();
	end
	// watchdog: about 140 host cycles of some 13 clocks each need near 0.09 ms; this allows far more
	initial
	begin
		#2000000;
		err_total++;
		finish_test();
	end
endmodule
`default_nettype wire
